//--- rtl/cpc_config_regs.sv
// Purpose: two-wire bus slave holding the three charge profile registers and the enable bit
// Assumes: scl, sda and vbat_low come from pins; temp_c comes from logic on ref_clk
// Notes:   open-drain sda; subaddress auto-increments after every data byte
`timescale 1ns/10ps
module cpc_config_regs import cpc_pkg::*; (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire logic               vbat_low,
  input  wire logic signed [7:0]  temp_c,
  input  wire logic [3:0]         warm_current_code,
  input  wire logic [3:0]         hot_current_code,
  output logic [12:0]             term_mv,
  output logic [10:0]             ilimit_ma,
  output logic [8:0]              eoc_ma,
  output cpc_band_e               band,
  output logic                    charge_en,
  output logic                    temp_fault,
  output logic                    cfg_access
);

  logic        scl_s1_r, scl_s2_r, scl_d_r;
  logic        sda_s1_r, sda_s2_r, sda_d_r;
  logic        vlow_s1_r, vlow_s2_r;
  cpc_state_e  st_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  sub_r;
  logic        rw_r;
  logic        sub_seen_r;
  logic        mack_r;
  logic        sda_out_r;
  logic        sda_oe_r;
  logic [7:0]  cfg1_r, cfg2_r, cfg3_r;
  logic        cfg_en_r;

  // pin synchronisers; the second stage feeds logic, the third stage only the scl/sda edge detectors
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
      {vlow_s1_r, vlow_s2_r}        <= 2'h0;
    end else if (ce) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_in, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
      {vlow_s1_r, vlow_s2_r}        <= {vbat_low, vlow_s1_r};
    end
  end

  logic       scl_rise, scl_fall, start_cond, stop_cond, byte_done, addr_hit;
  logic       wr_stb, sel_cfg1, sel_cfg2, sel_cfg3, sel_en, prof_ok;
  logic [7:0] rd_data;

  assign scl_rise   = scl_s2_r & ~scl_d_r;
  assign scl_fall   = ~scl_s2_r & scl_d_r;
  assign start_cond = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_cond  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  assign byte_done  = scl_fall && (bit_cnt_r == 4'h8);
  assign addr_hit   = (shift_r[7:1] == DEV_ADDR);
  assign wr_stb     = byte_done && (st_r == ST_WR);
  assign sel_cfg1   = (sub_r == SUB_CFG1);
  assign sel_cfg2   = (sub_r == SUB_CFG2);
  assign sel_cfg3   = (sub_r == SUB_CFG3);
  assign sel_en     = (sub_r == SUB_CFG_EN);
  assign prof_ok    = cfg_en_r;
  assign rd_data    = (sel_cfg1 && prof_ok) ? cfg1_r :
                      (sel_cfg2 && prof_ok) ? cfg2_r :
                      (sel_cfg3 && prof_ok) ? cfg3_r :
                      sel_en ? {7'h00, cfg_en_r} : 8'h00;

  // bus protocol engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r       <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      sub_r      <= 8'h00;
      rw_r       <= 1'b0;
      sub_seen_r <= 1'b0;
      mack_r     <= 1'b0;
      sda_out_r  <= 1'b0;
      sda_oe_r   <= 1'b0;
    end else if (ce) begin
      if (start_cond) begin
        st_r       <= ST_ADDR;
        bit_cnt_r  <= 4'h0;
        sub_seen_r <= 1'b0;
        sda_oe_r   <= 1'b0;
      end else if (stop_cond) begin
        st_r     <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (st_r)
          ST_ADDR, ST_SUB, ST_WR: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              shift_r   <= {shift_r[6:0], sda_s2_r};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (byte_done) begin
              if (st_r == ST_ADDR && !addr_hit) begin
                st_r <= ST_IDLE;
              end else begin
                if (st_r == ST_ADDR) rw_r <= shift_r[0];
                if (st_r == ST_SUB) begin
                  sub_r      <= shift_r;
                  sub_seen_r <= 1'b1;
                end
                if (st_r == ST_WR) sub_r <= sub_r + 8'h01;
                sda_out_r <= 1'b0;
                sda_oe_r  <= 1'b1;
                st_r      <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (rw_r) begin
                shift_r   <= rd_data;
                sda_out_r <= rd_data[7];
                sda_oe_r  <= ~rd_data[7];
                st_r      <= ST_RD;
              end else begin
                sda_oe_r <= 1'b0;
                st_r     <= sub_seen_r ? ST_WR : ST_SUB;
              end
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (byte_done) begin
              sda_oe_r <= 1'b0;
              sub_r    <= sub_r + 8'h01;
              st_r     <= ST_MACK;
            end else if (scl_fall) begin
              shift_r   <= {shift_r[6:0], 1'b0};
              sda_out_r <= shift_r[6];
              sda_oe_r  <= ~shift_r[6];
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s2_r;
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (mack_r) begin
                shift_r   <= rd_data;
                sda_out_r <= rd_data[7];
                sda_oe_r  <= ~rd_data[7];
                st_r      <= ST_RD;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // register file; profile writes are dropped until access is enabled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg1_r   <= CFG1_RST;
      cfg2_r   <= CFG2_RST;
      cfg3_r   <= CFG3_RST;
      cfg_en_r <= CFG_EN_RST;
    end else if (ce && wr_stb) begin
      if (sel_en) cfg_en_r <= shift_r[CFG_EN_BIT];
      else if (sel_cfg1 && prof_ok) cfg1_r <= shift_r;
      else if (sel_cfg2 && prof_ok) cfg2_r <= shift_r;
      else if (sel_cfg3 && prof_ok) cfg3_r <= shift_r;
    end
  end

  assign sda_out    = sda_out_r;
  assign sda_oe     = sda_oe_r;
  assign cfg_access = cfg_en_r;

  cpc_profile_select u_select (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .ce                (ce),
    .cfg1              (cfg1_r),
    .cfg2              (cfg2_r),
    .cfg3              (cfg3_r),
    .warm_current_code (warm_current_code),
    .hot_current_code  (hot_current_code),
    .temp_c            (temp_c),
    .vbat_low          (vlow_s2_r),
    .term_mv_r         (term_mv),
    .ilimit_ma_r       (ilimit_ma),
    .eoc_ma_r          (eoc_ma),
    .band_r            (band),
    .charge_en_r       (charge_en),
    .temp_fault_r      (temp_fault)
  );

  prof_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && wr_stb && sel_cfg1 && !cfg_en_r |=> $stable(cfg1_r))
    else $error("profile write taken while access disabled");
  prof_take_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && wr_stb && sel_cfg3 && cfg_en_r |=> cfg3_r == $past(shift_r))
    else $error("enabled profile write not stored");
  addr_miss_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && byte_done && st_r == ST_ADDR && !addr_hit && !start_cond && !stop_cond
    |=> st_r == ST_IDLE && !sda_oe_r)
    else $error("foreign address acknowledged");
  addr_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && byte_done && st_r == ST_ADDR && addr_hit && !start_cond && !stop_cond
    |=> sda_oe_r && !sda_out_r && st_r == ST_ACK)
    else $error("own address not acknowledged");

  write_c:  cover property (@(posedge ref_clk) disable iff (rst) ce && wr_stb && sel_cfg2 && cfg_en_r);
  read_c:   cover property (@(posedge ref_clk) disable iff (rst) st_r == ST_MACK ##1 st_r == ST_RD);
  locked_c: cover property (@(posedge ref_clk) disable iff (rst) ce && wr_stb && sel_cfg1 && !cfg_en_r);

endmodule // cpc_config_regs

//--- rtl/cpc_pkg.sv
// Purpose: constants, types and code tables for the charge profile configuration block
// Assumes: 10 MHz ref_clk, 7-bit bus address, 8-bit subaddress
package cpc_pkg;

  localparam logic [6:0] DEV_ADDR     = 7'h48;
  localparam logic [7:0] SUB_CFG1     = 8'h02;
  localparam logic [7:0] SUB_CFG2     = 8'h03;
  localparam logic [7:0] SUB_CFG3     = 8'h04;
  localparam logic [7:0] SUB_CFG_EN   = 8'h11;

  localparam logic [7:0] CFG1_RST     = 8'h00;
  localparam logic [7:0] CFG2_RST     = 8'h00;
  localparam logic [7:0] CFG3_RST     = 8'h00;
  localparam logic       CFG_EN_RST   = 1'b0;

  localparam int PRE_HI   = 7;
  localparam int PRE_LO   = 6;
  localparam int TCOLD_HI = 5;
  localparam int TCOLD_LO = 3;
  localparam int TNORM_HI = 2;
  localparam int TNORM_LO = 0;
  localparam int EOC_HI   = 7;
  localparam int EOC_LO   = 6;
  localparam int TWARM_HI = 5;
  localparam int TWARM_LO = 3;
  localparam int THOT_HI  = 2;
  localparam int THOT_LO  = 0;
  localparam int ICOLD_HI = 7;
  localparam int ICOLD_LO = 4;
  localparam int INORM_HI = 3;
  localparam int INORM_LO = 0;
  localparam int CFG_EN_BIT = 0;

  localparam logic [2:0] TERM_INVALID = 3'h7;

  localparam logic signed [7:0] T_LOW   = 8'sh00;
  localparam logic signed [7:0] T_COLD  = 8'sh0A;
  localparam logic signed [7:0] T_NORM  = 8'sh2D;
  localparam logic signed [7:0] T_WARM  = 8'sh32;
  localparam logic signed [7:0] T_HIGH  = 8'sh3C;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_SUB  = 7'b0000100,
    ST_WR   = 7'b0001000,
    ST_ACK  = 7'b0010000,
    ST_RD   = 7'b0100000,
    ST_MACK = 7'b1000000
  } cpc_state_e;

  typedef enum logic [4:0] {
    BAND_FAULT  = 5'b00001,
    BAND_COLD   = 5'b00010,
    BAND_NORMAL = 5'b00100,
    BAND_WARM   = 5'b01000,
    BAND_HOT    = 5'b10000
  } cpc_band_e;

  // 2-bit current code in mA, shared by pre-charge and end-of-charge
  function automatic logic [8:0] cpc_small_ma(input logic [1:0] code);
    case (code)
      2'h0:    cpc_small_ma = 9'h032;
      2'h1:    cpc_small_ma = 9'h064;
      2'h2:    cpc_small_ma = 9'h0B9;
      default: cpc_small_ma = 9'h172;
    endcase
  endfunction

  // 4-bit charge current code in mA
  function automatic logic [10:0] cpc_cur_ma(input logic [3:0] code);
    if (code == 4'h0) cpc_cur_ma = 11'h032;
    else cpc_cur_ma = 11'({7'h00, code} * 11'h064);
  endfunction

  // termination code in mV; invalid code gives zero
  function automatic logic [12:0] cpc_term_mv(input logic [2:0] code);
    case (code)
      3'h0:    cpc_term_mv = 13'h0F64;
      3'h1:    cpc_term_mv = 13'h0FA0;
      3'h2:    cpc_term_mv = 13'h0FD2;
      3'h3:    cpc_term_mv = 13'h1004;
      3'h4:    cpc_term_mv = 13'h1018;
      3'h5:    cpc_term_mv = 13'h1036;
      3'h6:    cpc_term_mv = 13'h1054;
      default: cpc_term_mv = 13'h0000;
    endcase
  endfunction

endpackage

//--- rtl/cpc_profile_select.sv
// Purpose: picks and decodes the charge settings of the present temperature band
// Assumes: temp_c and vbat_low already on ref_clk
// Notes:   all outputs registered, one cycle behind inputs
`timescale 1ns/10ps
module cpc_profile_select import cpc_pkg::*; (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic [7:0]         cfg1,
  input  wire logic [7:0]         cfg2,
  input  wire logic [7:0]         cfg3,
  input  wire logic [3:0]         warm_current_code,
  input  wire logic [3:0]         hot_current_code,
  input  wire logic signed [7:0]  temp_c,
  input  wire logic               vbat_low,
  output logic      [12:0]        term_mv_r,
  output logic      [10:0]        ilimit_ma_r,
  output logic      [8:0]         eoc_ma_r,
  output cpc_band_e               band_r,
  output logic                    charge_en_r,
  output logic                    temp_fault_r
);

  cpc_band_e   band_nxt;
  logic [2:0]  tcode;
  logic [3:0]  icode;
  logic        tcode_bad;
  logic [10:0] ilim_nxt;

  assign band_nxt = (temp_c < T_LOW || temp_c > T_HIGH) ? BAND_FAULT :
                    (temp_c <= T_COLD)                  ? BAND_COLD  :
                    (temp_c <= T_NORM)                  ? BAND_NORMAL :
                    (temp_c <= T_WARM)                  ? BAND_WARM  : BAND_HOT;

  assign tcode = (band_nxt == BAND_COLD)   ? cfg1[TCOLD_HI:TCOLD_LO] :
                 (band_nxt == BAND_NORMAL) ? cfg1[TNORM_HI:TNORM_LO] :
                 (band_nxt == BAND_WARM)   ? cfg2[TWARM_HI:TWARM_LO] :
                 (band_nxt == BAND_HOT)    ? cfg2[THOT_HI:THOT_LO]   : 3'h0;

  assign icode = (band_nxt == BAND_COLD)   ? cfg3[ICOLD_HI:ICOLD_LO] :
                 (band_nxt == BAND_NORMAL) ? cfg3[INORM_HI:INORM_LO] :
                 (band_nxt == BAND_WARM)   ? warm_current_code : hot_current_code;

  assign tcode_bad = (tcode == TERM_INVALID);
  assign ilim_nxt  = (band_nxt == BAND_FAULT) ? 11'h000 :
                     vbat_low ? {2'h0, cpc_small_ma(cfg1[PRE_HI:PRE_LO])} : cpc_cur_ma(icode);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      term_mv_r    <= 13'h0000;
      ilimit_ma_r  <= 11'h000;
      eoc_ma_r     <= 9'h000;
      band_r       <= BAND_FAULT;
      charge_en_r  <= 1'b0;
      temp_fault_r <= 1'b0;
    end else if (ce) begin
      term_mv_r    <= cpc_term_mv(tcode);
      ilimit_ma_r  <= ilim_nxt;
      eoc_ma_r     <= cpc_small_ma(cfg2[EOC_HI:EOC_LO]);
      band_r       <= band_nxt;
      charge_en_r  <= (band_nxt != BAND_FAULT) && !tcode_bad;
      temp_fault_r <= (band_nxt == BAND_FAULT);
    end
  end

  precharge_lim_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && vbat_low && temp_c >= T_LOW && temp_c <= T_HIGH
    |=> ilimit_ma_r == {2'h0, cpc_small_ma($past(cfg1[PRE_HI:PRE_LO]))})
    else $error("pre-charge limit not applied");
  eoc_map_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> eoc_ma_r == cpc_small_ma($past(cfg2[EOC_HI:EOC_LO])))
    else $error("end-of-charge current wrong");
  normal_term_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && temp_c > T_COLD && temp_c <= T_NORM |=> term_mv_r == cpc_term_mv($past(cfg1[TNORM_HI:TNORM_LO])))
    else $error("normal band termination wrong");
  temp_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && (temp_c < T_LOW || temp_c > T_HIGH) |=> temp_fault_r && !charge_en_r && ilimit_ma_r == 11'h000)
    else $error("out of range temperature did not stop charging");
  band_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && temp_c == T_NORM |=> band_r == BAND_NORMAL)
    else $error("boundary temperature took the upper band");
  bad_term_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && temp_c > T_WARM && temp_c <= T_HIGH && cfg2[THOT_HI:THOT_LO] == TERM_INVALID |=> !charge_en_r)
    else $error("invalid termination code let charging run");
  cold_cur_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !vbat_low && temp_c >= T_LOW && temp_c <= T_COLD
    |=> ilimit_ma_r == cpc_cur_ma($past(cfg3[ICOLD_HI:ICOLD_LO])))
    else $error("cold band current wrong");

  hot_band_c: cover property (@(posedge ref_clk) disable iff (rst) ce && band_r == BAND_HOT && charge_en_r);
  fault_c:    cover property (@(posedge ref_clk) disable iff (rst) temp_fault_r ##1 !temp_fault_r);

endmodule // cpc_profile_select

//--- testbench/cpc_i2c_host.sv
// Purpose: two-wire bus master model for the profile register block
// Assumes: ref_clk 10 MHz; scl low phase of 6 cycles and high phase of 5 cycles
// Notes:   open-drain: sda_drv low pulls the wire, high releases it
`timescale 1ns/10ps
module cpc_i2c_host (
  input  wire logic ref_clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // data changes mid-low, sampled at the end of the high phase
  task automatic put_bit(input logic b, output logic got);
    tick(3);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(5);
    got = sda_wire;
    scl <= 1'b0;
  endtask

  task automatic start_cond;
    tick(3);
    sda_drv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(5);
    sda_drv <= 1'b0;
    tick(5);
    scl <= 1'b0;
  endtask

  task automatic stop_cond;
    tick(3);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(5);
    sda_drv <= 1'b1;
    tick(5);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) put_bit(b[i], g);
    put_bit(1'b1, g);
    ack = ~g;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      d[i] = g;
    end
    put_bit(last, g);
  endtask

  task automatic write_reg(input logic [7:0] sub, input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte(8'h90, a0);
    send_byte(sub, a1);
    send_byte(data, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [7:0] sub, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte(8'h90, a0);
    send_byte(sub, a1);
    start_cond();
    send_byte(8'h91, a2);
    recv_byte(1'b1, d);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // two-byte read; master acks the first byte so the slave sends the byte at the next subaddress
  task automatic read_two(input logic [7:0] sub, output logic [15:0] d, output logic ok);
    logic a0, a1, a2;
    logic [7:0] hi, lo;
    start_cond();
    send_byte(8'h90, a0);
    send_byte(sub, a1);
    start_cond();
    send_byte(8'h91, a2);
    recv_byte(1'b0, hi);
    recv_byte(1'b1, lo);
    stop_cond();
    d = {hi, lo};
    ok = a0 & a1 & a2;
  endtask

  task automatic probe(input logic [7:0] addr_byte, output logic ok);
    start_cond();
    send_byte(addr_byte, ok);
    stop_cond();
  endtask
endmodule // cpc_i2c_host

//--- testbench/charge_profile_config_regs_tb.sv
// Purpose: self-checking bench for the charge profile register block
// Assumes: one 10 MHz clock; bus master model on scl and sda
// Notes:   sda wire is the and of both open-drain drivers with a pull-up
`timescale 1ns/10ps
module charge_profile_config_regs_tb import cpc_pkg::*;;
  logic              ref_clk, rst, ce, scl, sda_drv, sda_out, sda_oe, vbat_low, charge_en, temp_fault, cfg_access;
  logic signed [7:0] temp_c;
  logic [3:0]        warm_code, hot_code;
  logic [12:0]       term_mv;
  logic [10:0]       ilimit_ma;
  logic [8:0]        eoc_ma;
  cpc_band_e         band;
  wire logic         sda_wire = sda_drv & ~(sda_oe & ~sda_out);
  int                cycles, errors, checks_done;
  localparam logic [7:0] C1 = 8'h8B;
  localparam logic [7:0] C2 = 8'hEE;
  localparam logic [7:0] C3 = 8'hF2;

  cpc_config_regs dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .vbat_low(vbat_low), .temp_c(temp_c),
    .warm_current_code(warm_code), .hot_current_code(hot_code), .term_mv(term_mv),
    .ilimit_ma(ilimit_ma), .eoc_ma(eoc_ma), .band(band), .charge_en(charge_en),
    .temp_fault(temp_fault), .cfg_access(cfg_access));
  cpc_i2c_host host (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

  always #50 ref_clk = ~ref_clk;

  function automatic logic [15:0] term_exp(input logic [2:0] c);
    logic [15:0] t[8] = '{16'h0F64, 16'h0FA0, 16'h0FD2, 16'h1004, 16'h1018, 16'h1036, 16'h1054, 16'h0000};
    return t[c];
  endfunction
  function automatic logic [15:0] cur_exp(input logic [3:0] c);
    return (c == 4'h0) ? 16'h0032 : 16'({12'h000, c} * 16'h0064);
  endfunction
  function automatic logic [15:0] small_exp(input logic [1:0] c);
    logic [15:0] t[4] = '{16'h0032, 16'h0064, 16'h00B9, 16'h0172};
    return t[c];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] data);
    logic ok;
    host.write_reg(sub, data, ok);
    chk({15'h0, ok}, 16'h0001);
  endtask
  task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    host.read_reg(sub, d, ok);
    chk({15'h0, ok}, 16'h0001);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic set_env(input logic signed [7:0] t, input logic vl);
    @(posedge ref_clk);
    temp_c <= t;
    vbat_low <= vl;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic t_locked;
    chk({15'h0, cfg_access}, 16'h0000);
    wr(8'h02, 8'h5A);
    rd(8'h02, 8'h00);
    wr(8'h11, 8'h01);
    chk({15'h0, cfg_access}, 16'h0001);
    rd(8'h11, 8'h01);
    $display("test locked done");
  endtask

  task automatic t_regs;
    logic ok;
    logic [15:0] w;
    wr(8'h02, C1);
    wr(8'h03, C2);
    wr(8'h04, C3);
    rd(8'h02, C1);
    rd(8'h03, C2);
    rd(8'h04, C3);
    host.read_two(8'h03, w, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(w, {C2, C3});
    rd(8'h07, 8'h00);
    host.probe(8'hA0, ok);
    chk({15'h0, ok}, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_bands;
    logic signed [7:0] tv[10] = '{-8'sd1, 8'sd0, 8'sd10, 8'sd11, 8'sd45, 8'sd46, 8'sd50, 8'sd51, 8'sd60, 8'sd61};
    cpc_band_e bv[10] = '{BAND_FAULT, BAND_COLD, BAND_COLD, BAND_NORMAL, BAND_NORMAL,
                          BAND_WARM, BAND_WARM, BAND_HOT, BAND_HOT, BAND_FAULT};
    logic [15:0] te, ie;
    for (int i = 0; i < 10; i++) begin
      set_env(tv[i], 1'b0);
      te = (bv[i] == BAND_COLD) ? term_exp(C1[5:3]) : (bv[i] == BAND_NORMAL) ? term_exp(C1[2:0]) :
           (bv[i] == BAND_WARM) ? term_exp(C2[5:3]) : (bv[i] == BAND_HOT) ? term_exp(C2[2:0]) : term_exp(3'h0);
      ie = (bv[i] == BAND_COLD) ? cur_exp(C3[7:4]) : (bv[i] == BAND_NORMAL) ? cur_exp(C3[3:0]) :
           (bv[i] == BAND_WARM) ? cur_exp(warm_code) : (bv[i] == BAND_HOT) ? cur_exp(hot_code) : 16'h0;
      chk({11'h0, band}, {11'h0, bv[i]});
      chk(16'(term_mv), te);
      chk(16'(ilimit_ma), ie);
      chk({15'h0, charge_en}, {15'h0, bv[i] != BAND_FAULT});
      chk({15'h0, temp_fault}, {15'h0, bv[i] == BAND_FAULT});
    end
    set_env(8'sd70, 1'b1);
    chk(16'(ilimit_ma), 16'h0000);
    chk(16'(eoc_ma), small_exp(C2[7:6]));
    $display("test bands done");
  endtask

  task automatic t_codes;
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      wr(8'h04, {k, k});
      wr(8'h02, {k[1:0], 3'h1, 3'(i % 7)});
      wr(8'h03, {k[1:0], 3'h5, 3'h6});
      set_env(8'sd25, 1'b0);
      chk(16'(ilimit_ma), cur_exp(k));
      chk(16'(term_mv), term_exp(3'(i % 7)));
      chk(16'(eoc_ma), small_exp(k[1:0]));
      set_env(8'sd5, 1'b0);
      chk(16'(ilimit_ma), cur_exp(k));
      set_env(8'sd25, 1'b1);
      chk(16'(ilimit_ma), small_exp(k[1:0]));
    end
    $display("test codes done");
  endtask

  task automatic t_invalid;
    wr(8'h02, 8'h8F);
    set_env(8'sd25, 1'b0);
    chk(16'(term_mv), 16'h0000);
    chk({15'h0, charge_en}, 16'h0000);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({15'h0, cfg_access}, 16'h0000);
    rd(8'h02, 8'h00);
    $display("test invalid done");
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    temp_c = 8'sd25;
    vbat_low = 1'b0;
    warm_code = 4'h0;
    hot_code = 4'h7;
    cycles = 0;
    errors = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_locked();
    t_regs();
    t_bands();
    t_codes();
    t_invalid();
    finish_test();
  end
endmodule // charge_profile_config_regs_tb
